// ### verilog/dpe_map.svh
// Constants for the dual-port serial memory block
`ifndef DPE_MAP_SVH
`define DPE_MAP_SVH
`define DPE_CLK_NS     40
`define DPE_FLT_NS     50
`define DPE_FLT_CYC    ((`DPE_FLT_NS + `DPE_CLK_NS - 1) / `DPE_CLK_NS)
`define DPE_WR_NS      5000000
`define DPE_WR_CYC     (`DPE_WR_NS / `DPE_CLK_NS)
`define DPE_BUSY_W     17
`define DPE_CODE       4'hA
`define DPE_MON_WORDS  128
`define DPE_HOST_WORDS 512
`define DPE_FIFO_DEPTH 8
`define DPE_PIN_IDLE   6'h3F
`endif

// ### verilog/dpe_pkg.sv
// Types shared by the dual-port serial memory block
package dpe_pkg;
  typedef enum logic [2:0] {
    ST_IDLE  = 3'h0,
    ST_CTRL  = 3'h1,
    ST_ADDR  = 3'h2,
    ST_WDATA = 3'h3,
    ST_RDATA = 3'h4
  } dpe_state_e;
  typedef struct packed {
    dpe_state_e      st;
    logic [3:0]      bitc;
    logic            ackph;
    logic [7:0]      sh;
    logic [8:0]      ptr;
    logic            oe;
    logic            wrote;
    logic [16:0]     busy;
  } dpe_port_s;
  typedef struct packed {
    logic [7:0]      byte_q;
    logic [3:0]      cnt;
    logic [6:0]      fptr;
    logic            oe;
  } dpe_strm_s;
endpackage

// ### verilog/dpe_top.sv
// Dual-port two-wire serial memory: read path, write protect, streaming
`timescale 1ns/1ns
`default_nettype none
`include "dpe_map.svh"

module dpe_fifo #(
  parameter int W = 8,
  parameter int D = 8
) (
  input  wire logic         core_clk,
  input  wire logic         srst,
  input  wire logic         in_valid,
  output logic              in_ready,
  input  wire logic [W-1:0] in_data,
  output logic              out_valid,
  input  wire logic         out_ready,
  output logic [W-1:0]      out_data
);
  logic [W-1:0]           mem_r [D];
  logic [$clog2(D)-1:0]   wp_r, wp_nxt, rp_r, rp_nxt;
  logic [$clog2(D):0]     cnt_r, cnt_nxt;
  logic                   push, pop;

  assign in_ready  = (cnt_r != ($clog2(D)+1)'(D));
  assign out_valid = (cnt_r != '0);
  assign out_data  = mem_r[rp_r];

  always_comb begin
    push    = in_valid & in_ready;
    pop     = out_valid & out_ready;
    wp_nxt  = push ? wp_r + 1'b1 : wp_r;
    rp_nxt  = pop ? rp_r + 1'b1 : rp_r;
    cnt_nxt = cnt_r;
    if (push && !pop) begin
      cnt_nxt = cnt_r + 1'b1;
    end else if (pop && !push) begin
      cnt_nxt = cnt_r - 1'b1;
    end
  end

  always_ff @(posedge core_clk) begin
    if (srst) begin
      wp_r  <= '0;
      rp_r  <= '0;
      cnt_r <= '0;
    end else begin
      wp_r  <= wp_nxt;
      rp_r  <= rp_nxt;
      cnt_r <= cnt_nxt;
    end
    if (push) begin
      mem_r[wp_r] <= in_data;
    end
  end
endmodule

// How it works
// - Monitor writes need stream pin high
// - Host write lock high blocks writes
// - Host write lock low allows writes
// - Direction bit one selects read
// - Each port has own pointer, engine
// - Current read returns last address plus one
// - Unacknowledged byte ends read transmission
// - Word address loads pointer before restart
// - Acknowledged byte continues sequential read
// - Pointer increments after each word
// - All bus inputs synchronised and filtered
// - Stream bits go out on mon_data
// - Monitor data edges in clock high frame
// - Host data edges in clock high frame
// - mon_clock signalling enters bidirectional mode
// - Streaming lasts while mon_clock stays high
// - One stream bit per stream rising edge
// - Data lines are open drain only
// - Acknowledge only control code 1010
// - Host block select is address MSB
// - No acknowledge during programming cycle
module dpe_top #(
  parameter int unsigned WR_CYC = `DPE_WR_CYC
) (
  input  wire logic core_clk,
  input  wire logic srst,
  input  wire logic mon_clock,
  input  wire logic mon_data_i,
  output logic      mon_data_o,
  output logic      mon_data_oe,
  input  wire logic mon_stream_clock_wp,
  input  wire logic host_clock,
  input  wire logic host_data_i,
  output logic      host_data_o,
  output logic      host_data_oe,
  input  wire logic host_write_lock,
  output logic      mon_bidir
);
  import dpe_pkg::*;

  // ****************************************
  // Input conditioning
  // ****************************************
  logic [5:0]     s1_r, s2_r;
  logic [4:0]     flt_r, flt_nxt, fltp_r;
  logic [1:0]     fcnt_r [5];
  logic [1:0]     fcnt_nxt [5];

  always_comb begin
    for (int i = 0; i < 5; i++) begin
      flt_nxt[i]  = flt_r[i];
      fcnt_nxt[i] = 2'h0;
      if (s2_r[i] != flt_r[i]) begin
        // Spikes shorter than the filter time never reach the engines
        if (fcnt_r[i] == 2'(`DPE_FLT_CYC - 1)) begin
          flt_nxt[i] = s2_r[i];
        end else begin
          fcnt_nxt[i] = fcnt_r[i] + 2'h1;
        end
      end
    end
  end

  always_ff @(posedge core_clk) begin
    if (srst) begin
      s1_r   <= `DPE_PIN_IDLE;
      s2_r   <= `DPE_PIN_IDLE;
      flt_r  <= 5'h1F;
      fltp_r <= 5'h1F;
      for (int i = 0; i < 5; i++) fcnt_r[i] <= 2'h0;
    end else begin
      s1_r   <= {host_write_lock, mon_stream_clock_wp, host_data_i, host_clock, mon_data_i, mon_clock};
      s2_r   <= s1_r;
      flt_r  <= flt_nxt;
      fltp_r <= flt_r;
      for (int i = 0; i < 5; i++) fcnt_r[i] <= fcnt_nxt[i];
    end
  end

  // ****************************************
  // Two-wire slave engines
  // ****************************************
  logic [7:0]     mon_mem [`DPE_MON_WORDS];
  logic [7:0]     host_mem [`DPE_HOST_WORDS];
  dpe_port_s      pt_r [2];
  dpe_port_s      pt_nxt [2];
  logic [1:0]     we, wp_ok, act, rise_w, fall_w, strt_w, stop_w;
  logic [8:0]     wa [2];
  logic [7:0]     wd [2];
  logic           bidir_r, bidir_nxt;

  function automatic logic [8:0] ptr_wrap(input int p, input logic [8:0] v);
    ptr_wrap = (p == 1) ? v : {2'h0, v[6:0]};
  endfunction

  assign wp_ok = {~s2_r[5], flt_r[4]};
  assign act   = {1'b1, bidir_r};

  always_comb begin
    dpe_port_s  n;
    logic       sda;
    logic [8:0] ra;
    logic [7:0] rb;
    n = '0;
    sda = 1'b1;
    ra = '0;
    rb = '0;
    for (int p = 0; p < 2; p++) begin
      n         = pt_r[p];
      sda       = flt_r[2*p+1];
      rise_w[p] = flt_r[2*p] & ~fltp_r[2*p];
      fall_w[p] = ~flt_r[2*p] & fltp_r[2*p];
      // Data moving while the clock stays high frames a transfer
      strt_w[p] = flt_r[2*p] & fltp_r[2*p] & fltp_r[2*p+1] & ~sda;
      stop_w[p] = flt_r[2*p] & fltp_r[2*p] & ~fltp_r[2*p+1] & sda;
      we[p]     = 1'b0;
      wa[p]     = n.ptr;
      wd[p]     = n.sh;
      ra        = (p == 1 && n.st == ST_CTRL) ? {n.sh[1], n.ptr[7:0]} : n.ptr;
      rb        = (p == 1) ? host_mem[ra] : mon_mem[ra[6:0]];
      if (n.busy != '0) n.busy = n.busy - 17'h1;
      if (!act[p]) begin
        n.st = ST_IDLE;
        n.oe = 1'b0;
      end else if (strt_w[p]) begin
        n.st    = ST_CTRL;
        n.bitc  = 4'h0;
        n.ackph = 1'b0;
        n.oe    = 1'b0;
      end else if (stop_w[p]) begin
        n.st = ST_IDLE;
        n.oe = 1'b0;
        if (n.wrote) n.busy = 17'(WR_CYC);
        n.wrote = 1'b0;
      end else if (rise_w[p]) begin
        if (n.ackph) begin
          if (n.st == ST_RDATA && sda) n.st = ST_IDLE;
        end else if (n.st != ST_IDLE && n.bitc < 4'h8) begin
          n.sh   = {n.sh[6:0], sda};
          n.bitc = n.bitc + 4'h1;
        end
      end else if (fall_w[p]) begin
        if (n.st == ST_IDLE) begin
          n.oe = 1'b0;
        end else if (!n.ackph && n.bitc == 4'h8) begin
          n.ackph = 1'b1;
          if (n.st == ST_RDATA) begin
            n.oe = 1'b0;
          end else if (n.busy == '0 && (n.st != ST_CTRL || n.sh[7:4] == `DPE_CODE)) begin
            n.oe = 1'b1;
          end else begin
            n.st = ST_IDLE;
            n.oe = 1'b0;
          end
        end else if (n.ackph) begin
          n.ackph = 1'b0;
          n.bitc  = 4'h0;
          n.oe    = 1'b0;
          case (n.st)
            ST_CTRL: begin
              n.ptr = ra;
              if (n.sh[0]) begin
                // Pointer already names the next word: current read
                n.st  = ST_RDATA;
                n.sh  = rb;
                n.oe  = ~rb[7];
                n.ptr = ptr_wrap(p, ra + 9'h1);
              end else begin
                n.st = ST_ADDR;
              end
            end
            ST_ADDR: begin
              n.ptr = ptr_wrap(p, {n.ptr[8], n.sh});
              n.st  = ST_WDATA;
            end
            ST_WDATA: begin
              we[p]   = wp_ok[p];
              n.wrote = n.wrote | wp_ok[p];
              n.ptr   = ptr_wrap(p, n.ptr + 9'h1);
            end
            ST_RDATA: begin
              n.sh  = rb;
              n.oe  = ~rb[7];
              n.ptr = ptr_wrap(p, n.ptr + 9'h1);
            end
            default: n.st = ST_IDLE;
          endcase
        end else if (n.st == ST_RDATA) begin
          n.oe = ~n.sh[7];
        end
      end
      pt_nxt[p] = n;
    end
  end

  // Entry into bidirectional mode is one-way until srst clears it
  assign bidir_nxt = bidir_r | (~flt_r[0] & fltp_r[0]);

  // ****************************************
  // Transmit-only stream
  // ****************************************
  dpe_strm_s      st_r, st_nxt;
  logic           srise, fin_rdy, fout_vld, fout_rdy;
  logic [7:0]     fout_dat;

  assign srise    = flt_r[4] & ~fltp_r[4] & ~bidir_r;
  assign fout_rdy = srise & (st_r.cnt == 4'h0);

  // The FIFO hides the memory read behind the slow stream edges
  dpe_fifo #(
    .W (8),
    .D (`DPE_FIFO_DEPTH)
  ) u_fifo (
    .core_clk  (core_clk),
    .srst      (srst),
    .in_valid  (~bidir_r),
    .in_ready  (fin_rdy),
    .in_data   (mon_mem[st_r.fptr]),
    .out_valid (fout_vld),
    .out_ready (fout_rdy),
    .out_data  (fout_dat)
  );

  always_comb begin
    st_nxt = st_r;
    if (fin_rdy && !bidir_r) st_nxt.fptr = st_r.fptr + 7'h1;
    if (srise) begin
      if (st_r.cnt != 4'h0) begin
        st_nxt.oe     = ~st_r.byte_q[7];
        st_nxt.byte_q = {st_r.byte_q[6:0], 1'b0};
        st_nxt.cnt    = st_r.cnt - 4'h1;
      end else if (fout_vld) begin
        st_nxt.oe     = ~fout_dat[7];
        st_nxt.byte_q = {fout_dat[6:0], 1'b0};
        st_nxt.cnt    = 4'h7;
      end else begin
        st_nxt.oe = 1'b0;
      end
    end
  end

  always_ff @(posedge core_clk) begin
    if (srst) begin
      pt_r[0]      <= '0;
      pt_r[1]      <= '0;
      st_r         <= '0;
      bidir_r      <= 1'b0;
      mon_data_oe  <= 1'b0;
      host_data_oe <= 1'b0;
      mon_data_o   <= 1'b0;
      host_data_o  <= 1'b0;
      mon_bidir    <= 1'b0;
    end else begin
      pt_r[0]      <= pt_nxt[0];
      pt_r[1]      <= pt_nxt[1];
      st_r         <= st_nxt;
      bidir_r      <= bidir_nxt;
      mon_data_oe  <= bidir_r ? pt_r[0].oe : st_r.oe;
      host_data_oe <= pt_r[1].oe;
      mon_data_o   <= 1'b0;
      host_data_o  <= 1'b0;
      mon_bidir    <= bidir_r;
    end
  end

  // Arrays kept out of the reset process so they can be preloaded from outside
  always @(posedge core_clk) begin
    if (we[0]) mon_mem[wa[0][6:0]] <= wd[0];
    if (we[1]) host_mem[wa[1]] <= wd[1];
  end

  // ****************************************
  // Checks
  // ****************************************
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (srst);

  mon_wp_a: assert property (we[0] |-> flt_r[4] && bidir_r)
    else $error("monitor write while protected");
  host_lock_a: assert property (we[1] |-> !s2_r[5])
    else $error("host write while locked");
  host_open_a: assert property ((pt_r[1].st == ST_WDATA && pt_r[1].ackph && fall_w[1]
    && !strt_w[1] && !stop_w[1] && !s2_r[5]) |-> we[1])
    else $error("host write dropped while unlocked");
  read_sel_a: assert property ((pt_r[1].st == ST_CTRL && pt_r[1].ackph && fall_w[1]
    && pt_r[1].sh[0] && !strt_w[1] && !stop_w[1]) |=> pt_r[1].st == ST_RDATA)
    else $error("read not selected");
  ptr_step_a: assert property (we[1] |=> pt_r[1].ptr == $past(pt_r[1].ptr) + 9'h1)
    else $error("pointer did not step");
  mon_wrap_a: assert property (pt_r[0].ptr[8:7] == 2'h0)
    else $error("monitor pointer out of range");
  strm_edge_a: assert property ((!bidir_r && $past(!bidir_r, 2) && $changed(mon_data_oe))
    |-> $past(srise, 2))
    else $error("stream bit moved without stream edge");
  open_drain_a: assert property (!mon_data_o && !host_data_o)
    else $error("data line driven high");
  bidir_hold_a: assert property (bidir_r |=> bidir_r [*3])
    else $error("left bidirectional mode");
  busy_ack_a: assert property (pt_r[1].busy != '0 |-> !pt_r[1].oe ##1 !host_data_oe)
    else $error("acknowledge during programming");
  ctrl_code_a: assert property ((pt_r[1].st == ST_CTRL && pt_r[1].oe) |-> pt_r[1].sh[7:4] == `DPE_CODE)
    else $error("bad control code acknowledged");

  cover property (bidir_r && !$past(bidir_r));
  cover property (we[1] ##[1:1000] pt_r[1].st == ST_RDATA);
  cover property (!fin_rdy);
  cover property (pt_r[1].st == ST_RDATA && pt_r[1].ackph && rise_w[1] && !flt_r[3]);
endmodule
`default_nettype wire

// ### test/dpe_master.sv
// Two-wire bus master model for one port of the memory
`timescale 1ns/1ns
`default_nettype none
module dpe_master (
  input  wire logic core_clk,
  input  wire logic sda,
  output logic      scl,
  output logic      pull
);
  logic [8:0] rx;
  event       done;
  // ****************
  // Bus phases
  // ****************
  initial begin
    scl = 1'b1;
    pull = 1'b0;
  end
  task automatic q(input int n);
    repeat (n) @(negedge core_clk);
  endtask
  // Data moves mid-low, well clear of both clock edges
  task automatic bit1(input logic b, output logic r);
    q(5);
    pull = !b;
    q(10);
    scl = 1'b1;
    q(10);
    r = sda;
    scl = 1'b0;
  endtask
  task automatic start();
    q(5);
    pull = 1'b0;
    q(5);
    scl = 1'b1;
    q(10);
    pull = 1'b1;
    q(10);
    scl = 1'b0;
  endtask
  task automatic stop();
    q(5);
    pull = 1'b1;
    q(5);
    scl = 1'b1;
    q(10);
    pull = 1'b0;
    q(10);
  endtask
  task automatic xfer(input logic [7:0] w, input logic rd, input logic more);
    logic [7:0] d;
    logic       r;
    for (int i = 7; i >= 0; i--) begin
      bit1(rd | w[i], r);
      d[i] = r;
    end
    bit1(rd ? !more : 1'b1, r);
    rx = rd ? {1'b0, d} : {!r, 8'h00};
    ->done;
  endtask
endmodule
`default_nettype wire

// ### test/tb_dual_port_eeprom_read_wp.sv
// Self-checking bench for the dual-port serial memory
`timescale 1ns/1ns
`default_nettype none
`define CHK(a, e) begin n_tests++; if ((a) !== (e)) begin err_total++; \
  $display("ERROR %0t: got %h exp %h", $time, a, e); end end
module tb_dual_port_eeprom_read_wp;
  localparam int WR = 400;
  localparam int LIMIT = 60000;
  logic        core_clk = 1'b0;
  logic        srst;
  logic        mon_stream_clock_wp;
  logic        host_write_lock;
  logic        mon_data_o, mon_data_oe, host_data_o, host_data_oe, mon_bidir;
  wire logic   mon_clock, host_clock, mon_pull, host_pull, mon_data, host_data;
  int          err_total = 0;
  int          n_tests = 0;
  logic        s_arm = 1'b0;
  logic [8:0]  exq[$];
  logic [7:0]  wb[4], hw[4], rb[4];
  logic [15:0] sw;
  // Pull-ups on both data wires
  assign mon_data = !(mon_data_oe | mon_pull);
  assign host_data = !(host_data_oe | host_pull);
  always #20 core_clk = ~core_clk;
  dpe_master ph (.core_clk(core_clk), .sda(host_data), .scl(host_clock), .pull(host_pull));
  dpe_master pm (.core_clk(core_clk), .sda(mon_data), .scl(mon_clock), .pull(mon_pull));
  dpe_top #(.WR_CYC(WR)) dut_u (
    .core_clk(core_clk), .srst(srst), .mon_clock(mon_clock), .mon_data_i(mon_data),
    .mon_data_o(mon_data_o), .mon_data_oe(mon_data_oe), .mon_stream_clock_wp(mon_stream_clock_wp),
    .host_clock(host_clock), .host_data_i(host_data), .host_data_o(host_data_o),
    .host_data_oe(host_data_oe), .host_write_lock(host_write_lock), .mon_bidir(mon_bidir));
  // ****************
  // Helpers
  // ****************
  task automatic q(input int n);
    repeat (n) @(negedge core_clk);
  endtask
  task automatic wrap_up();
    if (err_total == 0 && n_tests > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  task automatic got(input logic [8:0] v);
    logic [8:0] e;
    e = exq.size() ? exq.pop_front() : 9'h1FF;
    `CHK(v, e)
    `CHK(host_data_o | mon_data_o, 1'b0)
  endtask
  always @(ph.done) got(ph.rx);
  always @(pm.done) got(pm.rx);
  always @(posedge mon_stream_clock_wp) if (s_arm) got({8'h00, mon_data});
  task automatic frm(input logic p, input logic s);
    if (p && s) pm.start();
    else if (p) pm.stop();
    else if (s) ph.start();
    else ph.stop();
  endtask
  task automatic op(input logic p, input logic [7:0] w, input logic r, input logic m, input logic [8:0] e);
    exq.push_back(e);
    if (p) pm.xfer(w, r, m);
    else ph.xfer(w, r, m);
  endtask
  task automatic wr(input logic p, input logic [8:0] a, input int n);
    frm(p, 1'b1);
    op(p, {4'hA, 2'b00, a[8], 1'b0}, 1'b0, 1'b0, 9'h100);
    op(p, a[7:0], 1'b0, 1'b0, 9'h100);
    for (int i = 0; i < n; i++)
      op(p, wb[i], 1'b0, 1'b0, 9'h100);
    frm(p, 1'b0);
  endtask
  task automatic rd(input logic p, input logic [8:0] a, input logic rnd, input int n);
    frm(p, 1'b1);
    if (rnd) begin
      op(p, {4'hA, 2'b00, a[8], 1'b0}, 1'b0, 1'b0, 9'h100);
      op(p, a[7:0], 1'b0, 1'b0, 9'h100);
      frm(p, 1'b1);
    end
    op(p, {4'hA, 2'b00, a[8], 1'b1}, 1'b0, 1'b0, 9'h100);
    for (int i = 0; i < n; i++)
      op(p, 8'hFF, 1'b1, i < n - 1, {1'b0, rb[i]});
    frm(p, 1'b0);
  endtask
  // ****************
  // Sequence
  // ****************
  initial begin
    srst = 1'b1;
    host_write_lock = 1'b0;
    mon_stream_clock_wp = 1'b0;
    void'($urandom(32'hC069));
    foreach (wb[i]) wb[i] = 8'($urandom());
    sw = {wb[0], wb[1]};
    dut_u.mon_mem[0] = wb[0];
    dut_u.mon_mem[1] = wb[1];
    dut_u.mon_mem[2] = wb[2];
    q(3);
    srst = 1'b0;
    q(6);
    for (int k = 0; k < 17; k++) begin
      if (k > 0) exq.push_back({8'h00, sw[16 - k]});
      mon_stream_clock_wp = 1'b1;
      q(4);
      mon_stream_clock_wp = 1'b0;
      s_arm = 1'b1;
      q(4);
    end
    s_arm = 1'b0;
    `CHK(mon_bidir, 1'b0)
    frm(1'b1, 1'b1);
    frm(1'b1, 1'b0);
    q(10);
    `CHK(mon_bidir, 1'b1)
    foreach (wb[i]) wb[i] = 8'($urandom());
    hw = wb;
    wr(1'b0, 9'h1FE, 4);
    frm(1'b0, 1'b1);
    op(1'b0, 8'hA0, 1'b0, 1'b0, 9'h000);
    frm(1'b0, 1'b0);
    q(WR);
    frm(1'b0, 1'b1);
    op(1'b0, 8'h50, 1'b0, 1'b0, 9'h000);
    frm(1'b0, 1'b0);
    rb = hw;
    rd(1'b0, 9'h1FE, 1'b1, 3);
    mon_stream_clock_wp = 1'b1;
    foreach (wb[i]) wb[i] = 8'($urandom());
    wr(1'b1, 9'h07F, 2);
    q(WR);
    rb = wb;
    mon_stream_clock_wp = 1'b0;
    wb[0] = ~wb[0];
    wr(1'b1, 9'h07F, 1);
    q(20);
    rd(1'b1, 9'h07F, 1'b1, 2);
    rb[0] = hw[3];
    rd(1'b0, 9'h001, 1'b0, 1);
    host_write_lock = 1'b1;
    wb[0] = ~hw[0];
    wr(1'b0, 9'h1FE, 1);
    q(20);
    rb[0] = hw[0];
    rd(1'b0, 9'h1FE, 1'b1, 1);
    q(10);
    wrap_up();
  end
  // Hang guard, well above the expected run length
  initial begin
    repeat (LIMIT) @(posedge core_clk);
    err_total++;
    wrap_up();
  end
endmodule
`default_nettype wire
